// File: core/tcs_timer_clock_select.sv
// Clock-source selection for six counter/timers, delivered as count-enable ticks.
// Assumes an 8-bit register port on clk_sys; ext_osc and event pins are asynchronous.
//
// Overview of operation
// RULE1 - Timer 3 upper byte ticks on sysclk when its upper select is 1, else its alternate clock.
// RULE2 - Timer 3 lower select picks sysclk (1) or its alternate clock (0) for the whole or low byte.
// RULE3 - Timer 2 upper byte ticks on sysclk when its upper select is 1, else its alternate clock.
// RULE4 - Timer 2 lower select picks sysclk (1) or its alternate clock (0) for the whole or low byte.
// RULE5 - Timer 1 uses sysclk when its select is 1, else the prescaler, unless counting events.
// RULE6 - Timer 0 uses sysclk when its select is 1, else the prescaler, unless counting events.
// RULE7 - Prescaler code 00 divides sysclk by 12, 01 by 4, 10 by 48.
// RULE8 - Prescaler code 11 gives the synchronized external oscillator divided by 8.
// RULE9 - The upper four bits of the second register read as zero and ignore writes.
// RULE10 - Timer 5 upper byte ticks on sysclk when its upper select is 1, else its alternate clock.
// RULE11 - Timer 5 lower select picks sysclk (1) or its alternate clock (0) for the whole or low byte.
// RULE12 - Timer 4 upper byte ticks on sysclk when its upper select is 1, else its alternate clock.
// RULE13 - Timer 4 lower select picks sysclk (1) or its alternate clock (0) for the whole or low byte.
// RULE14 - Alternate clock for timers 2 to 5 is sysclk/12 or external oscillator/8.
// RULE15 - With event counting set, timer 0 (and 1) advance on each falling edge of the input pin.
// RULE16 - Every selected source leaves as a registered count enable on clk_sys: one-cycle pulses, but held high when sysclk is selected.
`timescale 1ns/1ps
module tcs_timer_clock_select (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       ext_osc,
  input  wire logic       timer0_pin,
  input  wire logic       timer1_pin,
  input  wire logic       timer0_event_count_select,
  input  wire logic       timer1_event_count_select,
  input  wire logic [3:0] alt_clock_choice,
  output logic            timer0_tick,
  output logic            timer1_tick,
  output logic      [3:0] timer_lower_tick,
  output logic      [3:0] timer_upper_tick
);

  // alt_clock_choice[i] and tick index i map to timers 2..5
  logic [7:0] timer_clock_source_reg_q;
  logic [7:0] timer45_clock_source_reg_q;
  logic [2:0] osc_sync_q;
  logic [2:0] pin0_sync_q;
  logic [2:0] pin1_sync_q;
  logic       timer0_tick_q;
  logic       timer1_tick_q;
  logic [3:0] lower_tick_q;
  logic [3:0] upper_tick_q;

  // Address match, shared by the read and write paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addr_hit

  wire hit_main = addr_hit(reg_addr, tcs_pkg::CLOCK_SOURCE_ADDR);
  wire hit_45   = addr_hit(reg_addr, tcs_pkg::CLOCK45_SOURCE_ADDR);
  wire wr_main  = reg_wr && hit_main;
  wire wr_45    = reg_wr && hit_45;

  wire [1:0] timer01_divider_choice =
    timer_clock_source_reg_q[tcs_pkg::DIV_CHOICE_LSB +: 2];
  wire timer0_sysclk_sel    = timer_clock_source_reg_q[tcs_pkg::T0_SYSCLK_BIT];
  wire timer1_sysclk_sel    = timer_clock_source_reg_q[tcs_pkg::T1_SYSCLK_BIT];
  wire timer2_lower_src_sel = timer_clock_source_reg_q[tcs_pkg::T2_LOWER_BIT];
  wire timer2_upper_src_sel = timer_clock_source_reg_q[tcs_pkg::T2_UPPER_BIT];
  wire timer3_lower_src_sel = timer_clock_source_reg_q[tcs_pkg::T3_LOWER_BIT];
  wire timer3_upper_src_sel = timer_clock_source_reg_q[tcs_pkg::T3_UPPER_BIT];
  wire timer4_lower_src_sel = timer45_clock_source_reg_q[tcs_pkg::T4_LOWER_BIT];
  wire timer4_upper_src_sel = timer45_clock_source_reg_q[tcs_pkg::T4_UPPER_BIT];
  wire timer5_lower_src_sel = timer45_clock_source_reg_q[tcs_pkg::T5_LOWER_BIT];
  wire timer5_upper_src_sel = timer45_clock_source_reg_q[tcs_pkg::T5_UPPER_BIT];

  wire [3:0] lower_sel = {timer5_lower_src_sel, timer4_lower_src_sel,
                          timer3_lower_src_sel, timer2_lower_src_sel};
  wire [3:0] upper_sel = {timer5_upper_src_sel, timer4_upper_src_sel,
                          timer3_upper_src_sel, timer2_upper_src_sel};

  // Upper nibble of the second register never holds a one
  wire [7:0] clock45_readback = timer45_clock_source_reg_q & tcs_pkg::CLOCK45_WRITE_MASK;

  // Register read path
  assign reg_rdata = hit_main ? timer_clock_source_reg_q :
                     hit_45   ? clock45_readback :
                     8'h00; // [RULE9]

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      timer_clock_source_reg_q <= tcs_pkg::CLOCK_SOURCE_RESET;
    else if (wr_main)
      timer_clock_source_reg_q <= reg_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      timer45_clock_source_reg_q <= tcs_pkg::CLOCK45_SOURCE_RESET;
    else if (wr_45)
      timer45_clock_source_reg_q <= reg_wdata & tcs_pkg::CLOCK45_WRITE_MASK; // [RULE9]
  end

  // Two-stage synchronisers, third stage for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      osc_sync_q <= 3'h0;
    else
      osc_sync_q <= {osc_sync_q[1:0], ext_osc};
  end

  // Event pins idle high, so ones after reset avoid a false fall
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pin0_sync_q <= 3'h7;
    else
      pin0_sync_q <= {pin0_sync_q[1:0], timer0_pin};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pin1_sync_q <= 3'h7;
    else
      pin1_sync_q <= {pin1_sync_q[1:0], timer1_pin};
  end

  wire osc_rise  = osc_sync_q[1] && !osc_sync_q[2];                 // [RULE8]
  wire pin0_fall = !pin0_sync_q[1] && pin0_sync_q[2];               // [RULE15]
  wire pin1_fall = !pin1_sync_q[1] && pin1_sync_q[2];

  wire sys_div12;
  wire sys_div4;
  wire sys_div48;
  wire ext_div8;

  tcs_tick_div #(.RATIO(tcs_pkg::SYS_DIV12)) u_div12 ( // [RULE7] [RULE14]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (1'b1),
    .tick_out (sys_div12)
  );

  tcs_tick_div #(.RATIO(tcs_pkg::SYS_DIV4)) u_div4 ( // [RULE7]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (1'b1),
    .tick_out (sys_div4)
  );

  tcs_tick_div #(.RATIO(tcs_pkg::SYS_DIV48)) u_div48 ( // [RULE7]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (1'b1),
    .tick_out (sys_div48)
  );

  tcs_tick_div #(.RATIO(tcs_pkg::EXT_DIV8)) u_ext8 ( // [RULE8] [RULE14]
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .tick_in  (osc_rise),
    .tick_out (ext_div8)
  );

  logic prescale_tick;
  always_comb
  begin
    unique case (timer01_divider_choice)
      tcs_pkg::DIV_SYS12: prescale_tick = sys_div12; // [RULE7]
      tcs_pkg::DIV_SYS4:  prescale_tick = sys_div4;  // [RULE7]
      tcs_pkg::DIV_SYS48: prescale_tick = sys_div48; // [RULE7]
      tcs_pkg::DIV_EXT8:  prescale_tick = ext_div8;  // [RULE8]
    endcase
  end

  wire t0_internal = timer0_sysclk_sel ? 1'b1 : prescale_tick; // [RULE6]
  wire t1_internal = timer1_sysclk_sel ? 1'b1 : prescale_tick; // [RULE5]
  wire t0_next = timer0_event_count_select ? pin0_fall : t0_internal; // [RULE6] [RULE15]
  wire t1_next = timer1_event_count_select ? pin1_fall : t1_internal; // [RULE5]

  // Timers 2..5 tick selection
  logic [3:0] alt_tick;
  logic [3:0] lower_next;
  logic [3:0] upper_next;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_tmr
      assign alt_tick[g]   = alt_clock_choice[g] ? ext_div8 : sys_div12; // [RULE14]
      // [RULE2] [RULE4] [RULE11] [RULE13]
      assign lower_next[g] = lower_sel[g] ? 1'b1 : alt_tick[g];
      // [RULE1] [RULE3] [RULE10] [RULE12]
      assign upper_next[g] = upper_sel[g] ? 1'b1 : alt_tick[g];
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      timer0_tick_q <= 1'b0;
      timer1_tick_q <= 1'b0;
    end
    else
    begin
      timer0_tick_q <= t0_next;     // [RULE16]
      timer1_tick_q <= t1_next;     // [RULE16]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      lower_tick_q <= 4'h0;
      upper_tick_q <= 4'h0;
    end
    else
    begin
      lower_tick_q <= lower_next;   // [RULE16]
      upper_tick_q <= upper_next;   // [RULE16]
    end
  end

  assign timer0_tick      = timer0_tick_q;
  assign timer1_tick      = timer1_tick_q;
  assign timer_lower_tick = lower_tick_q;
  assign timer_upper_tick = upper_tick_q;

endmodule : tcs_timer_clock_select

// File: core/tcs_pkg.sv
// Package for the timer clock select block: register map, fields, divide ratios.
// Assumes an 8-bit special-register style access port on the system clock.
package tcs_pkg;

  localparam logic [7:0] CLOCK_SOURCE_ADDR   = 8'h8e;
  localparam logic [7:0] CLOCK45_SOURCE_ADDR = 8'he4;
  localparam logic [7:0] CLOCK_SOURCE_RESET  = 8'h00;
  localparam logic [7:0] CLOCK45_SOURCE_RESET = 8'h00;
  localparam logic [7:0] CLOCK45_WRITE_MASK  = 8'h0f;

  // Fields of the first register
  localparam int T3_UPPER_BIT = 7;
  localparam int T3_LOWER_BIT = 6;
  localparam int T2_UPPER_BIT = 5;
  localparam int T2_LOWER_BIT = 4;
  localparam int T1_SYSCLK_BIT = 3;
  localparam int T0_SYSCLK_BIT = 2;
  localparam int DIV_CHOICE_LSB = 0;

  // Fields of the second register
  localparam int T5_UPPER_BIT = 3;
  localparam int T5_LOWER_BIT = 2;
  localparam int T4_UPPER_BIT = 1;
  localparam int T4_LOWER_BIT = 0;

  // Prescaler codes
  localparam logic [1:0] DIV_SYS12  = 2'h0;
  localparam logic [1:0] DIV_SYS4   = 2'h1;
  localparam logic [1:0] DIV_SYS48  = 2'h2;
  localparam logic [1:0] DIV_EXT8   = 2'h3;

  // Divide ratios
  localparam int SYS_DIV12 = 12;
  localparam int SYS_DIV4  = 4;
  localparam int SYS_DIV48 = 48;
  localparam int EXT_DIV8  = 8;

endpackage : tcs_pkg

// File: core/tcs_tick_div.sv
// Tick divider: one-cycle pulse every RATIO enabled cycles.
// Assumes tick_in is on clk_sys; a free-running count with no clear.
`timescale 1ns/1ps
module tcs_tick_div #(
  parameter int RATIO = 12
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic tick_in,
  output logic      tick_out
);

  localparam int CW = $clog2(RATIO);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          out_q;
  wire           wrap = tick_in && (cnt_q == LAST);

  assign cnt_d    = !tick_in ? cnt_q : (wrap ? '0 : cnt_q + CW'(1));
  assign tick_out = out_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= wrap;
    end
  end

endmodule : tcs_tick_div

// File: verif/tcs_timer_clock_select_props.sv
// Checker for the timer clock select block.
// Sees only top-level ports; keeps its own copy of the two registers.
`timescale 1ns/1ps
module tcs_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_osc,
  input wire logic       timer0_pin,
  input wire logic       timer1_pin,
  input wire logic       timer0_event_count_select,
  input wire logic       timer1_event_count_select,
  input wire logic [3:0] alt_clock_choice,
  input wire logic       timer0_tick,
  input wire logic       timer1_tick,
  input wire logic [3:0] timer_lower_tick,
  input wire logic [3:0] timer_upper_tick
);
  logic [7:0] r1_q;
  logic [7:0] r2_q;
  wire  [3:0] lo_sel = {r2_q[2], r2_q[0], r1_q[6], r1_q[4]};
  wire  [3:0] up_sel = {r2_q[3], r2_q[1], r1_q[7], r1_q[5]};
  wire        ev0    = timer0_event_count_select;
  wire        s4     = !ev0 && r1_q[2:0] == 3'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      {r1_q, r2_q} <= 16'h0000;
    else if (reg_wr && reg_addr == 8'h8e)
      r1_q <= reg_wdata;
    else if (reg_wr && reg_addr == 8'he4)
      r2_q <= reg_wdata & 8'h0f;
  end
  a_t0_sysclk: assert property (r1_q[2] && !ev0 |=> timer0_tick)
    else $error("timer0 tick not held under sysclk select");
  a_t1_sysclk: assert property (r1_q[3] && !timer1_event_count_select |=> timer1_tick)
    else $error("timer1 tick not held under sysclk select");
  a_lower_sysclk: assert property (lo_sel != 4'h0 |=>
    (timer_lower_tick & $past(lo_sel)) == $past(lo_sel)) else $error("lower tick not held");
  a_upper_sysclk: assert property (up_sel != 4'h0 |=>
    (timer_upper_tick & $past(up_sel)) == $past(up_sel)) else $error("upper tick not held");
  a_first_readback: assert property (reg_addr == 8'h8e |-> reg_rdata == r1_q)
    else $error("first register readback wrong");
  a_second_readback: assert property (reg_addr == 8'he4 |-> reg_rdata == r2_q)
    else $error("second register readback wrong");
  a_prescale_pulse: assert property (!ev0 && !r1_q[2] && $stable(r1_q) && $stable(ev0)
    && timer0_tick |=> !timer0_tick) else $error("prescaled tick wider than one cycle");
  a_div4_period: assert property (s4 ##1 (timer0_tick && s4) ##1 s4 [*3] |=> timer0_tick)
    else $error("divide by four period wrong");
  a_event_tick: assert property (ev0 && $fell(timer0_pin) |-> ##[1:6] (timer0_tick || !ev0))
    else $error("pin fall gave no timer0 tick");
  c_event: cover property (ev0 && timer0_tick);
  c_div4: cover property (s4 ##1 timer0_tick);
  c_upper: cover property (up_sel != 4'h0 ##1 timer_upper_tick != 4'h0);
endmodule : tcs_checker

bind tcs_timer_clock_select tcs_checker u_chk (
  .clk_sys                   (clk_sys),
  .sys_rst                   (sys_rst),
  .reg_addr                  (reg_addr),
  .reg_wr                    (reg_wr),
  .reg_wdata                 (reg_wdata),
  .reg_rdata                 (reg_rdata),
  .ext_osc                   (ext_osc),
  .timer0_pin                (timer0_pin),
  .timer1_pin                (timer1_pin),
  .timer0_event_count_select (timer0_event_count_select),
  .timer1_event_count_select (timer1_event_count_select),
  .alt_clock_choice          (alt_clock_choice),
  .timer0_tick               (timer0_tick),
  .timer1_tick               (timer1_tick),
  .timer_lower_tick          (timer_lower_tick),
  .timer_upper_tick          (timer_upper_tick)
);

// File: verif/tcs_tick_counter.sv
// Timer-side model: counts the count-enable pulses of every tick output.
// Assumes ticks are clk_sys count enables; clr starts a fresh window.
`timescale 1ns/1ps
module tcs_tick_counter (
  input  wire logic             clk_sys,
  input  wire logic             clr,
  input  wire logic [9:0]       ticks,
  output logic      [9:0][15:0] cnt_q
);
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < 10; i++)
      cnt_q[i] <= clr ? 16'h0000 : cnt_q[i] + 16'(ticks[i]);
  end
endmodule : tcs_tick_counter

// File: verif/tb_timer_clock_select.sv
// Testbench for the timer clock select block.
// Drives register port, pins and oscillator; ticks are counted in the timer model.
`timescale 1ns/1ps
module tb_timer_clock_select;
  typedef struct {logic [7:0] r1, r2; logic [3:0] alt; logic [1:0] ev; logic [15:0] e0, e1;}
    tcs_row_type;
  logic             clk_sys = 1'b0;
  logic             sys_rst = 1'b1;
  logic [7:0]       reg_addr = 8'h00;
  logic             reg_wr = 1'b0;
  logic [7:0]       reg_wdata = 8'h00;
  logic [7:0]       reg_rdata;
  logic             ext_osc = 1'b0;
  logic             pin = 1'b1;
  logic             pin1 = 1'b1;
  logic             timer0_event_count_select = 1'b0;
  logic             timer1_event_count_select = 1'b0;
  logic [3:0]       alt_clock_choice = 4'h0;
  logic             timer0_tick;
  logic             timer1_tick;
  logic [3:0]       timer_lower_tick;
  logic [3:0]       timer_upper_tick;
  logic             clr = 1'b0;
  logic [9:0][15:0] cnt_q;
  logic [3:0]       lo;
  logic [3:0]       up;
  int               n_mismatch = 0;
  int               checked = 0;
  tcs_row_type rows [5] = '{
    '{8'h00, 8'h00, 4'h0, 2'h0, 16'h0014, 16'h0014},
    '{8'h01, 8'h0f, 4'hf, 2'h0, 16'h003c, 16'h003c},
    '{8'hf6, 8'hf5, 4'h5, 2'h0, 16'h00f0, 16'h0005},
    '{8'h0b, 8'h0a, 4'ha, 2'h0, 16'h0006, 16'h00f0},
    '{8'h0c, 8'h00, 4'h3, 2'h3, 16'h0018, 16'h0010}};
  tcs_timer_clock_select DUT (
    .clk_sys                   (clk_sys),
    .sys_rst                   (sys_rst),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .ext_osc                   (ext_osc),
    .timer0_pin                (pin),
    .timer1_pin                (pin1),
    .timer0_event_count_select (timer0_event_count_select),
    .timer1_event_count_select (timer1_event_count_select),
    .alt_clock_choice          (alt_clock_choice),
    .timer0_tick               (timer0_tick),
    .timer1_tick               (timer1_tick),
    .timer_lower_tick          (timer_lower_tick),
    .timer_upper_tick          (timer_upper_tick)
  );
  tcs_tick_counter u_cnt (.clk_sys(clk_sys), .clr(clr), .cnt_q(cnt_q),
    .ticks({timer_upper_tick, timer_lower_tick, timer1_tick, timer0_tick}));
  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1 reg_addr = a;
    #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  function automatic logic [15:0] alt_cnt(input logic sys, input logic ext);
    return sys ? 16'h00f0 : (ext ? 16'h0006 : 16'h0014);
  endfunction : alt_cnt
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    #3;
    forever #20 ext_osc = ~ext_osc;
  end
  initial
  begin
    #45;
    forever #40 pin = ~pin;
  end
  initial
  begin
    #45;
    forever #60 pin1 = ~pin1;
  end
  initial
  begin
    #60000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    rd(8'h8e, 8'h00);
    rd(8'he4, 8'h00);
    foreach (rows[k])
    begin
      wr(8'h8e, rows[k].r1);
      wr(8'he4, rows[k].r2);
      alt_clock_choice = rows[k].alt;
      {timer1_event_count_select, timer0_event_count_select} = rows[k].ev;
      lo = {rows[k].r2[2], rows[k].r2[0], rows[k].r1[6], rows[k].r1[4]};
      up = {rows[k].r2[3], rows[k].r2[1], rows[k].r1[7], rows[k].r1[5]};
      rd(8'h8e, rows[k].r1);
      rd(8'he4, rows[k].r2 & 8'h0f);
      rd(8'h00, 8'h00);
      repeat (8) @(posedge clk_sys);
      #1 clr = 1'b1;
      @(posedge clk_sys);
      #1 clr = 1'b0;
      repeat (240) @(posedge clk_sys);
      #1 chk("timer0_tick", rows[k].e0, cnt_q[0]);
      chk("timer1_tick", rows[k].e1, cnt_q[1]);
      for (int i = 0; i < 4; i++)
      begin
        chk("timer_lower_tick", alt_cnt(lo[i], rows[k].alt[i]), cnt_q[i+2]);
        chk("timer_upper_tick", alt_cnt(up[i], rows[k].alt[i]), cnt_q[i+6]);
      end
    end
    wr(8'h8f, 8'hff);
    timer0_event_count_select = 1'b0;
    rd(8'h8e, 8'h0c);
    chk("timer0_tick", 16'h0001, {15'h0000, timer0_tick});
    wr(8'he4, 8'hff);
    rd(8'he4, 8'h0f);
    @(posedge clk_sys);
    #1 sys_rst = 1'b1;
    @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk("timer0_tick", 16'h0000, {15'h0000, timer0_tick});
    rd(8'h8e, 8'h00);
    rd(8'he4, 8'h00);
    end_of_test();
  end
endmodule : tb_timer_clock_select
